// [core/eip_event_unit.sv]
// Purpose: Event interrupt pulse unit with status latching
// Assumes: Mode and event inputs come from logic on the same clock
// Notes: Event request pin is push/pull; sampled for config in init mode
// How it works
// - In normal or stop mode an interrupt drives the pin low for 100 us.
// - Pin stays high at least 100 us between consecutive pulses.
// - Raising an interrupt never changes the operating mode.
// - Class bit 0 selects wake-only class (default), 1 selects global class.
// - Outside stop-mode entry, wake status raises interrupt only if enabled as a wake source.
// - Bus timeout is a wake source gated by its mask, ignoring class.
// - Global class adds failure status; pin level status never interrupts.
// - Undervoltage, watchdog, short, thermal, fail, reset flags never interrupt.
// - Stop-mode entry with wake status still set raises an interrupt.
// - Visible status registers update at each falling pulse edge.
// - Events stay latched until the host clears them; pin level excluded.
// - Global class timing and latching match the wake-only class.
// - In init mode the pin is sampled to pick the hardware configuration.
// - The sampled configuration level is filtered 10 us before acceptance.
`timescale 1ns/1ns
module eip_event_unit (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_mode,
  input wire logic [7:0] i_wake_one_evt,
  input wire logic [7:0] i_wake_two_evt,
  input wire logic i_bus_timeout_evt,
  input wire logic [7:0] i_fail_evt,
  input wire logic [7:0] i_pin_level,
  input wire logic i_pin_in,
  output logic o_pin_out,
  output logic o_pin_oe,
  output logic o_cfg_level,
  output logic o_cfg_valid,
  output logic o_irq
);
  // Bit 7 of the failure word carries the non-interrupting flags
  localparam logic [7:0] FAIL_IRQ_MASK = 8'h7F;
  localparam int TO_BIT = 7;

  eip_pulse_if pif ();
  eip_pulse_timer u_timer (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .pif(pif));

  logic [7:0] ctrl_r, en1_r, en2_r;
  logic [7:0] wk1_lat_r, wk2_lat_r, fail_lat_r;
  logic [7:0] wk1_vis_r, wk2_vis_r, fail_vis_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  logic pend_r, req_r, stop_pend_r;
  logic [1:0] mode_q_r;
  logic [2:0] pin_sync_r;
  logic cand_r;
  logic [eip_pkg::FILT_W-1:0] filt_r;
  logic wr_wk1, wr_wk2, wr_fail;
  logic [7:0] wk1_src, wk2_src, fail_src;
  logic trig, stop_entry, active_mode;

  // Address decode used by writes and reads
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  assign wr_wk1 = i_wr && hit(i_addr, eip_pkg::ADDR_WAKE_ONE);
  assign wr_wk2 = i_wr && hit(i_addr, eip_pkg::ADDR_WAKE_TWO);
  assign wr_fail = i_wr && hit(i_addr, eip_pkg::ADDR_FAIL);
  assign active_mode = (i_mode == eip_pkg::MODE_NORMAL) || (i_mode == eip_pkg::MODE_STOP);
  assign stop_entry = (i_mode == eip_pkg::MODE_STOP) && (mode_q_r != eip_pkg::MODE_STOP);

  // Interrupt sources; mode is never driven from here
  always_comb begin
    wk1_src = wk1_lat_r & en1_r;
    wk2_src = wk2_lat_r & en2_r;
    wk2_src[TO_BIT] = wk2_lat_r[TO_BIT] & ~ctrl_r[eip_pkg::CTRL_TO_MASK_BIT];
    fail_src = ctrl_r[eip_pkg::CTRL_GLOBAL_BIT] ? (fail_lat_r & FAIL_IRQ_MASK) : 8'h00;
    trig = ((|(wk1_src & ~wk1_vis_r)) || (|(wk2_src & ~wk2_vis_r)) || (|(fail_src & ~fail_vis_r))
      || stop_pend_r) && active_mode;
  end

  // Control and wake enable registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= eip_pkg::RST_ZERO;
      en1_r <= eip_pkg::RST_ZERO;
      en2_r <= eip_pkg::RST_ZERO;
      irq_mask_r <= eip_pkg::RST_IRQ_MASK;
    end else if (i_wr) begin
      if (hit(i_addr, eip_pkg::ADDR_CTRL)) begin
        ctrl_r <= i_wdata;
      end else if (hit(i_addr, eip_pkg::ADDR_WAKE_EN1)) begin
        en1_r <= i_wdata;
      end else if (hit(i_addr, eip_pkg::ADDR_WAKE_EN2)) begin
        en2_r <= i_wdata;
      end else if (hit(i_addr, eip_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_r <= i_wdata[1:0];
      end
    end
  end

  // Internal latches: set wins over write-one-to-clear
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wk1_lat_r <= eip_pkg::RST_ZERO;
      wk2_lat_r <= eip_pkg::RST_ZERO;
      fail_lat_r <= eip_pkg::RST_ZERO;
    end else begin
      wk1_lat_r <= (wk1_lat_r & ~(wr_wk1 ? i_wdata : 8'h00)) | i_wake_one_evt;
      wk2_lat_r <= (wk2_lat_r & ~(wr_wk2 ? i_wdata : 8'h00)) | i_wake_two_evt
        | {i_bus_timeout_evt, 7'h00};
      fail_lat_r <= (fail_lat_r & ~(wr_fail ? i_wdata : 8'h00)) | i_fail_evt;
    end
  end

  // Visible copies refresh at pulse fall; clears act at once, except in the fall cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wk1_vis_r <= eip_pkg::RST_ZERO;
      wk2_vis_r <= eip_pkg::RST_ZERO;
      fail_vis_r <= eip_pkg::RST_ZERO;
    end else if (pif.fall) begin
      wk1_vis_r <= wk1_lat_r;
      wk2_vis_r <= wk2_lat_r;
      fail_vis_r <= fail_lat_r;
    end else begin
      wk1_vis_r <= wk1_vis_r & ~(wr_wk1 ? i_wdata : 8'h00);
      wk2_vis_r <= wk2_vis_r & ~(wr_wk2 ? i_wdata : 8'h00);
      fail_vis_r <= fail_vis_r & ~(wr_fail ? i_wdata : 8'h00);
    end
  end

  // Stop-entry check and pending request scheduling
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q_r <= eip_pkg::MODE_INIT;
      stop_pend_r <= 1'b0;
      pend_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      mode_q_r <= i_mode;
      if (stop_entry && ((|wk1_lat_r) || (|wk2_lat_r))) begin
        stop_pend_r <= 1'b1;
      end else if (pif.fall) begin
        stop_pend_r <= 1'b0;
      end
      if (trig && !pif.fall) begin
        pend_r <= 1'b1;
      end else if (pif.fall) begin
        pend_r <= 1'b0;
      end
      req_r <= (pend_r || trig) && !pif.fall && !pif.busy && active_mode;
    end
  end

  assign pif.req = req_r;

  // Pin drive: push/pull only outside init mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_out <= 1'b1;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_oe <= (i_mode != eip_pkg::MODE_INIT);
      o_pin_out <= ~pif.pin_low;
    end
  end

  // Three-stage pin synchroniser
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], i_pin_in};
    end
  end

  // Configuration level filter during init mode
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cand_r <= 1'b0;
      filt_r <= '0;
      o_cfg_level <= 1'b0;
      o_cfg_valid <= 1'b0;
    end else if (i_mode == eip_pkg::MODE_INIT && pin_sync_r[1] == pin_sync_r[2]) begin
      if (pin_sync_r[2] != cand_r) begin
        cand_r <= pin_sync_r[2];
        filt_r <= '0;
      end else if (filt_r == eip_pkg::FILT_W'(eip_pkg::CFG_FILT_CYC - 1)) begin
        o_cfg_level <= cand_r;
        o_cfg_valid <= 1'b1;
      end else begin
        filt_r <= filt_r + 1'b1;
      end
    end
  end

  // Block status: pulse issued, stop-entry interrupt
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_stat_r <= 2'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((i_wr && hit(i_addr, eip_pkg::ADDR_IRQ_STAT)) ? i_wdata[1:0] : 2'h0))
        | {stop_entry && ((|wk1_lat_r) || (|wk2_lat_r)), pif.fall};
    end
  end

  // Interrupt output
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (hit(i_addr, eip_pkg::ADDR_CTRL)) begin
      o_rdata <= ctrl_r;
    end else if (hit(i_addr, eip_pkg::ADDR_WAKE_ONE)) begin
      o_rdata <= wk1_vis_r;
    end else if (hit(i_addr, eip_pkg::ADDR_WAKE_TWO)) begin
      o_rdata <= wk2_vis_r;
    end else if (hit(i_addr, eip_pkg::ADDR_FAIL)) begin
      o_rdata <= fail_vis_r;
    end else if (hit(i_addr, eip_pkg::ADDR_WAKE_EN1)) begin
      o_rdata <= en1_r;
    end else if (hit(i_addr, eip_pkg::ADDR_WAKE_EN2)) begin
      o_rdata <= en2_r;
    end else if (hit(i_addr, eip_pkg::ADDR_PIN_LEVEL)) begin
      o_rdata <= i_pin_level;
    end else if (hit(i_addr, eip_pkg::ADDR_IRQ_STAT)) begin
      o_rdata <= {6'h00, irq_stat_r};
    end else if (hit(i_addr, eip_pkg::ADDR_IRQ_MASK)) begin
      o_rdata <= {6'h00, irq_mask_r};
    end else if (hit(i_addr, eip_pkg::ADDR_CFG)) begin
      o_rdata <= {6'h00, o_cfg_valid, o_cfg_level};
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule : eip_event_unit

// [core/eip_pkg.sv]
// Purpose: Shared constants for the event interrupt pulse unit
// Assumes: 25 MHz reference clock
// Notes: Times in ns, cycle counts derived from the clock period
package eip_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned PULSE_WIDTH_NS = 100000;
  localparam int unsigned PULSE_GAP_TIME_NS = 100000;
  localparam int unsigned CFG_FILTER_NS = 10000;
  localparam int unsigned PULSE_CYC = PULSE_WIDTH_NS / CLK_PERIOD_NS;
  localparam int unsigned GAP_CYC = PULSE_GAP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CFG_FILT_CYC = CFG_FILTER_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam int FILT_W = 9;
  localparam int REG_W = 8;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WAKE_ONE = 8'h04;
  localparam logic [7:0] ADDR_WAKE_TWO = 8'h08;
  localparam logic [7:0] ADDR_FAIL = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_EN1 = 8'h10;
  localparam logic [7:0] ADDR_WAKE_EN2 = 8'h14;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  localparam logic [7:0] ADDR_CFG = 8'h24;
  // Control bits
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_TO_MASK_BIT = 1;
  // Block interrupt status bits
  localparam int IRQ_PULSE_BIT = 0;
  localparam int IRQ_STOP_BIT = 1;
  localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  typedef enum logic [1:0] {
    MODE_INIT,
    MODE_NORMAL,
    MODE_STOP,
    MODE_OTHER
  } eip_mode_t;
endpackage : eip_pkg

// [core/eip_pulse_if.sv]
// Purpose: Carrier between the scheduler and the pulse timer
// Assumes: Single clock domain
// Notes: Request is a level, fall is a one-cycle pulse
`timescale 1ns/1ns
interface eip_pulse_if;
  logic req;
  logic busy;
  logic fall;
  logic pin_low;
  modport sched (output req, input busy, input fall, input pin_low);
  modport timer (input req, output busy, output fall, output pin_low);
endinterface : eip_pulse_if

// [core/eip_pulse_timer.sv]
// Purpose: Fixed-width low pulse followed by a minimum high gap
// Assumes: Request held until fall seen
// Notes: Tolerance follows the reference oscillator
`timescale 1ns/1ns
module eip_pulse_timer (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  eip_pulse_if.timer pif
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_GAP} eip_tstate_t;
  eip_tstate_t state_r;
  logic [eip_pkg::CNT_W-1:0] cnt_r;
  localparam logic [eip_pkg::CNT_W-1:0] PULSE_LAST = eip_pkg::CNT_W'(eip_pkg::PULSE_CYC - 1);
  localparam logic [eip_pkg::CNT_W-1:0] GAP_LAST = eip_pkg::CNT_W'(eip_pkg::GAP_CYC - 1);

  // Low phase then gap phase, counted in reference cycles
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      pif.fall <= 1'b0;
      pif.pin_low <= 1'b0;
    end else begin
      pif.fall <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (pif.req) begin
            state_r <= ST_LOW;
            cnt_r <= '0;
            pif.fall <= 1'b1;
            pif.pin_low <= 1'b1;
          end
        end
        ST_LOW: begin
          if (cnt_r == PULSE_LAST) begin
            state_r <= ST_GAP;
            cnt_r <= '0;
            pif.pin_low <= 1'b0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_GAP: begin
          if (cnt_r == GAP_LAST) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign pif.busy = (state_r != ST_IDLE);
endmodule : eip_pulse_timer

// [sim/eip_assertions.sv]
// Purpose: Pin timing checks for the pulse unit
// Assumes: Single clock, async active-low reset
// Notes: Long counts kept in helper counters
`timescale 1ns/1ns
module eip_assertions (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_mode,
  input wire logic o_pin_out,
  input wire logic o_pin_oe,
  input wire logic o_cfg_valid,
  input wire logic o_irq
);
  logic [11:0] low_r;
  logic [11:0] high_r;
  logic [8:0] up_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // Low time, high time since last pulse, uptime
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_r <= 12'h000;
      high_r <= 12'hFFF;
      up_r <= 9'h000;
    end else begin
      low_r <= o_pin_out ? 12'h000 : low_r + 12'h001;
      high_r <= !o_pin_out ? 12'h000 : (high_r == 12'hFFF ? high_r : high_r + 12'h001);
      up_r <= (up_r == 9'h1FF) ? up_r : up_r + 9'h001;
    end
  end
  AST_WIDTH: assert property ($rose(o_pin_out) |-> low_r == 12'd2500)
    else $error("pulse width wrong");
  AST_WIDTH_CAP: assert property (low_r <= 12'd2500)
    else $error("pulse too long");
  AST_GAP: assert property ($fell(o_pin_out) |-> high_r >= 12'd2500)
    else $error("gap too short");
  AST_MODE: assert property ($fell(o_pin_out) |-> $past(i_mode) inside {2'h1, 2'h2})
    else $error("pulse outside normal or stop");
  AST_INIT_OE: assert property ($past(i_mode) == 2'h0 |-> !o_pin_oe)
    else $error("pin driven in init");
  AST_DRIVEN: assert property (!o_pin_out |-> o_pin_oe)
    else $error("low without drive");
  AST_HOLD: assert property ($fell(o_pin_out) |-> (!o_pin_out) [*8])
    else $error("pulse glitch");
  AST_FILTER: assert property ($rose(o_cfg_valid) |-> up_r >= 9'd250)
    else $error("config taken early");
  AST_CFG_KEEP: assert property (o_cfg_valid |=> o_cfg_valid)
    else $error("config lost");
  cover property ($fell(o_pin_out));
  cover property ($rose(o_cfg_valid));
  cover property ($rose(o_irq));
endmodule : eip_assertions
bind eip_event_unit eip_assertions chk (.i_ref_clk, .i_arst_n, .i_mode, .o_pin_out, .o_pin_oe, .o_cfg_valid,
  .o_irq);

// [sim/eip_event_unit_bench.sv]
// Purpose: Self-checking bench for the pulse unit
// Assumes: 25 MHz clock, strap held high
// Notes: Expected pulse count kept beside host count
`timescale 1ns/1ns
module eip_event_unit_bench;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [1:0] i_mode = 2'h0;
  logic [7:0] i_wake_one_evt = 8'h00;
  logic [7:0] i_wake_two_evt = 8'h00;
  logic i_bus_timeout_evt = 1'b0;
  logic [7:0] i_fail_evt = 8'h00;
  logic [7:0] i_pin_level = 8'h00;
  logic strap = 1'b1;
  logic i_pin_in;
  logic [7:0] o_rdata;
  logic o_pin_out;
  logic o_pin_oe;
  logic o_cfg_level;
  logic o_cfg_valid;
  logic o_irq;
  logic [7:0] d;
  logic [7:0] v;
  int pulses;
  int exp_p = 0;
  int n;
  int mismatches = 0;
  int total_checks = 0;
  int seed = 32'h050b85fe;
  time t_fall = 0;
  time t_rise = 0;
  eip_event_unit uut (.i_ref_clk, .i_arst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mode,
    .i_wake_one_evt, .i_wake_two_evt, .i_bus_timeout_evt, .i_fail_evt, .i_pin_level, .i_pin_in,
    .o_pin_out, .o_pin_oe, .o_cfg_level, .o_cfg_valid, .o_irq);
  eip_host_model host (.i_ref_clk, .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_strap(strap),
    .o_pin_in(i_pin_in), .o_pulses(pulses));
  eip_pkg::eip_mode_t md;
  // Pin edge times, so width and gap do not depend on when a task starts
  always @(negedge o_pin_out) t_fall = $time;
  always @(posedge o_pin_out) t_rise = $time;
  // Clock
  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= x;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  // Bounded wait for a pin level, cycles left in n
  task automatic wait_pin(input logic lv, input int lim);
    n = 0;
    while (o_pin_out !== lv && n < lim) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n >= lim) begin
      mismatches++;
      complete_run();
    end
  endtask : wait_pin
  // One full pulse, optionally after a gap
  task automatic pulse(input bit gap);
    wait_pin(1'b0, 6000);
    if (gap) chk(16'((($time - t_rise) / 40) >= 2500), 16'h0001);
    exp_p++;
    wait_pin(1'b1, 3000);
    chk(16'(($time - t_fall) / 40), 16'd2500);
  endtask : pulse
  // One-cycle event on a chosen input group
  task automatic ev(input int g, input logic [7:0] x);
    @(posedge i_ref_clk);
    if (g == 1) i_wake_one_evt <= x;
    if (g == 2) i_wake_two_evt <= x;
    if (g == 3) i_fail_evt <= x;
    if (g == 4) i_bus_timeout_evt <= x[0];
    @(posedge i_ref_clk);
    i_bus_timeout_evt <= 1'b0;
    i_wake_one_evt <= 8'h00;
    i_wake_two_evt <= 8'h00;
    i_fail_evt <= 8'h00;
  endtask : ev
  // Quiet period, no new pulse expected
  task automatic quiet();
    repeat (3000) @(posedge i_ref_clk);
    chk(16'(pulses), 16'(exp_p));
  endtask : quiet
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    repeat (300) @(posedge i_ref_clk);
    chk({o_cfg_valid, o_cfg_level, o_pin_oe}, {1'b1, strap, 1'b0});
    rd(eip_pkg::ADDR_CFG);
    chk(d, {6'h00, 1'b1, strap});
    rd(eip_pkg::ADDR_CTRL);
    chk(d, 8'h00);
    rd(8'hFC);
    chk(d, 8'h00);
    i_pin_level <= 8'($random(seed));
    rd(eip_pkg::ADDR_PIN_LEVEL);
    chk(d, i_pin_level);
    $display("init done");
    md = eip_pkg::MODE_NORMAL;
    i_mode <= md;
    wr(eip_pkg::ADDR_IRQ_MASK, 8'h01);
    wr(eip_pkg::ADDR_WAKE_EN1, 8'hFF);
    v = 8'($random(seed));
    v = (v & 8'h7E) | 8'h01;
    ev(1, v);
    wait_pin(1'b0, 10);
    ev(1, 8'h80);
    rd(eip_pkg::ADDR_WAKE_ONE);
    chk(d, v);
    chk(o_irq, 1'b1);
    wr(eip_pkg::ADDR_IRQ_STAT, 8'h03);
    rd(eip_pkg::ADDR_IRQ_STAT);
    chk({d, o_irq}, 9'h000);
    pulse(0);
    pulse(1);
    rd(eip_pkg::ADDR_WAKE_ONE);
    chk(d, v | 8'h80);
    wr(eip_pkg::ADDR_WAKE_ONE, 8'hFF);
    rd(eip_pkg::ADDR_WAKE_ONE);
    chk(d, 8'h00);
    $display("wake done");
    wr(eip_pkg::ADDR_WAKE_EN2, 8'h00);
    ev(2, 8'h01);
    quiet();
    ev(3, 8'h01);
    quiet();
    wr(eip_pkg::ADDR_FAIL, 8'hFF);
    wr(eip_pkg::ADDR_CTRL, 8'h01);
    ev(3, 8'h02);
    pulse(1);
    ev(3, 8'h80);
    quiet();
    $display("class done");
    ev(4, 8'h01);
    pulse(1);
    wr(eip_pkg::ADDR_WAKE_TWO, 8'hFF);
    wr(eip_pkg::ADDR_CTRL, 8'h03);
    ev(4, 8'h01);
    quiet();
    wr(eip_pkg::ADDR_WAKE_TWO, 8'hFF);
    wr(eip_pkg::ADDR_CTRL, 8'h01);
    $display("timeout done");
    ev(1, 8'h01);
    pulse(1);
    md = eip_pkg::MODE_STOP;
    i_mode <= md;
    pulse(1);
    chk(i_mode, 2'h2);
    md = eip_pkg::MODE_INIT;
    i_mode <= md;
    ev(1, 8'h02);
    quiet();
    $display("stop done");
    complete_run();
  end
endmodule : eip_event_unit_bench

// [sim/eip_host_model.sv]
// Purpose: Host side of the event pin
// Assumes: Strap resistor sets the level when undriven
// Notes: Counts every falling edge as one interrupt
`timescale 1ns/1ns
module eip_host_model (
  input wire logic i_ref_clk,
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  input wire logic i_strap,
  output logic o_pin_in,
  output int o_pulses
);
  logic last_r = 1'b1;
  initial o_pulses = 0;
  // Wire level from drive enable and strap
  assign o_pin_in = i_pin_oe ? i_pin_out : i_strap;
  // Falling edge counter
  always @(posedge i_ref_clk) begin
    if (last_r && !o_pin_in) o_pulses <= o_pulses + 1;
    last_r <= o_pin_in;
  end
endmodule : eip_host_model
